/* cal_engine.sv */
`default_nettype none
module cal_engine
   import cal_ctrl_pkg::*;
(
   // Clock and hold
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       run,
   // Configuration
   input  wire logic       fg_sel,
   input  wire logic       os_en,
   input  wire logic       bg_en,
   input  wire logic [2:0] ofs_depth,
   input  wire logic [2:0] lin_avg,
   // Status
   output logic            fg_complete,
   output logic            halted,
   output logic            bg_active,
   output logic [4:0]      state
);
   cal_state_t state_r, state_nxt;
   logic [10:0] cnt_r, cnt_nxt;
   logic        done_r, done_nxt;
   logic        halt_r, halt_nxt;
   logic [10:0] fg_len, os_len;

   assign fg_len = {3'h0, FG_BASE} << lin_avg;
   assign os_len = {3'h0, FG_BASE} << ofs_depth;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      done_nxt  = done_r;
      halt_nxt  = halt_r;
      case (state_r)
         ST_HOLD: begin
            done_nxt = 1'b0;
            halt_nxt = 1'b0;
            if (run) begin
               state_nxt = ST_RESET;
               cnt_nxt   = {3'h0, RESET_CYCLES};
            end
         end
         ST_RESET: begin
            cnt_nxt = cnt_r - 11'h1;
            if (cnt_r == 11'h1) begin
               if (fg_sel) begin
                  state_nxt = ST_FG;
                  cnt_nxt   = fg_len;
               end else begin
                  state_nxt = ST_RUN;
                  done_nxt  = 1'b1;
                  halt_nxt  = !bg_en;
               end
            end
         end
         ST_FG: begin
            cnt_nxt = cnt_r - 11'h1;
            if (cnt_r == 11'h1) begin
               if (os_en) begin
                  state_nxt = ST_OS;
                  cnt_nxt   = os_len;
               end else begin
                  state_nxt = ST_RUN;
                  done_nxt  = 1'b1;
                  halt_nxt  = !bg_en;
               end
            end
         end
         ST_OS: begin
            cnt_nxt = cnt_r - 11'h1;
            if (cnt_r == 11'h1) begin
               state_nxt = ST_RUN;
               done_nxt  = 1'b1;
               halt_nxt  = !bg_en;
            end
         end
         ST_RUN: begin
            halt_nxt = !bg_en;
         end
         default: state_nxt = ST_HOLD;
      endcase
      if (!run) begin
         state_nxt = ST_HOLD;
         done_nxt  = 1'b0;
         halt_nxt  = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= ST_HOLD;
         cnt_r   <= 11'h0;
         done_r  <= 1'b0;
         halt_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         done_r  <= done_nxt;
         halt_r  <= halt_nxt;
      end
   end

   assign fg_complete = done_r;
   assign halted    = halt_r;
   assign bg_active = (state_r == ST_RUN) && bg_en;
   assign state     = state_r;

   a_done_needs_run: assert property (@(posedge mclk) disable iff (rst)
      done_r |-> $past(run)) else $error("done while held");
   a_restart_reset: assert property (@(posedge mclk) disable iff (rst)
      (state_r == ST_HOLD && run) |=> state_r == ST_RESET)
      else $error("no restart");
   a_skip_fg: assert property (@(posedge mclk) disable iff (rst)
      (state_r == ST_RESET && cnt_r == 11'h1 && !fg_sel && run) |=> done_r)
      else $error("skip not flagged");
   a_halt_no_bg: assert property (@(posedge mclk) disable iff (rst)
      (state_r == ST_RUN && $past(state_r) == ST_RUN && run && $past(run)
       && $past(bg_en) && bg_en) |-> !halt_r) else $error("halt wrong");
endmodule // cal_engine
`default_nettype wire

/* cal_ctrl_pkg.sv */
// Contract
// - Run bit one runs calibration; zero holds reset
// - Clearing run bit resets digital and link dividers
// - Background offset needs background calibration enabled
// - Foreground offset needs foreground calibration selected
// - Background enable bit turns continuous calibration on
// - Always reset values; foreground only when selected
// - Idle-core field picks uncalibrated core when background off
// - Offset averaging field bits six to four
// - Linearity averaging field bits two to zero
// - Reserved bits read back, reset zero, inert
// - Foreground-complete flag set when done or skipped
// - Halted flag set on stop, cleared on resume
`default_nettype none
package cal_ctrl_pkg;
   localparam logic [7:0] ADDR_RUN_EN  = 8'h61;
   localparam logic [7:0] ADDR_CFG0    = 8'h62;
   localparam logic [7:0] ADDR_CFG2    = 8'h64;
   localparam logic [7:0] ADDR_AVG     = 8'h68;
   localparam logic [7:0] ADDR_STATE   = 8'h6a;
   localparam logic [7:0] RST_RUN_EN   = 8'h01;
   localparam logic [7:0] RST_CFG0     = 8'h01;
   localparam logic [7:0] RST_CFG2     = 8'h02;
   localparam logic [7:0] RST_AVG      = 8'h61;
   localparam int         BIT_RUN      = 0;
   localparam int         BIT_FG       = 0;
   localparam int         BIT_BG       = 1;
   localparam int         BIT_OS       = 2;
   localparam int         BIT_BGOS     = 3;
   localparam int         BIT_FG_FIN   = 0;
   localparam int         BIT_HALTED   = 1;
   localparam int         OFS_LSB      = 4;
   localparam int         LIN_AVG_LSB  = 0;
   localparam logic [1:0] CORE_RSVD    = 2'h3;
   // Fixed reset step, and base foreground length scaled by averaging depth
   localparam logic [7:0] RESET_CYCLES = 8'h04;
   localparam logic [7:0] FG_BASE      = 8'h08;
   typedef enum logic [4:0] {
      ST_HOLD  = 5'h01,
      ST_RESET = 5'h02,
      ST_FG    = 5'h04,
      ST_OS    = 5'h08,
      ST_RUN   = 5'h10
   } cal_state_t;
endpackage
`default_nettype wire

/* cal_ctrl_regs.sv */
`default_nettype none
module cal_ctrl_regs
   import cal_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   // Calibration controls
   output logic            cal_hold,
   output logic            divider_reset,
   output logic            fg_offset_active,
   output logic            bg_offset_active,
   output logic            bg_cal_active,
   output logic [2:0]      core_disable,
   output logic [2:0]      offset_averaging_depth,
   output logic [2:0]      linearity_averaging_depth
);
   logic [7:0] run_r, run_nxt;
   logic [7:0] cfg0_r, cfg0_nxt;
   logic [7:0] cfg2_r, cfg2_nxt;
   logic [7:0] avg_r, avg_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic       fg_complete, halted, bg_act;
   logic [4:0] eng_state;
   logic       run;

   assign run = run_r[BIT_RUN];

   // ************************************
   // Register writes and reads
   // ************************************
   always_comb begin
      run_nxt  = run_r;
      cfg0_nxt = cfg0_r;
      cfg2_nxt = cfg2_r;
      avg_nxt  = avg_r;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_RUN_EN: run_nxt  = reg_wdata;
            ADDR_CFG0:   cfg0_nxt = reg_wdata;
            ADDR_CFG2:   cfg2_nxt = reg_wdata;
            ADDR_AVG:    avg_nxt  = reg_wdata;
            default:     ;
         endcase
      end
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_RUN_EN: rdata_nxt = run_r;
            ADDR_CFG0:   rdata_nxt = cfg0_r;
            ADDR_CFG2:   rdata_nxt = cfg2_r;
            ADDR_AVG:    rdata_nxt = avg_r;
            ADDR_STATE:  rdata_nxt = {6'h00, halted, fg_complete};
            default:     rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         run_r   <= RST_RUN_EN;
         cfg0_r  <= RST_CFG0;
         cfg2_r  <= RST_CFG2;
         avg_r   <= RST_AVG;
         rdata_r <= 8'h00;
      end else begin
         run_r   <= run_nxt;
         cfg0_r  <= cfg0_nxt;
         cfg2_r  <= cfg2_nxt;
         avg_r   <= avg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ************************************
   // Engine
   // ************************************
   cal_engine u_engine (
      .mclk      (mclk),
      .rst       (rst),
      .run       (run),
      .fg_sel    (cfg0_r[BIT_FG]),
      .os_en     (cfg0_r[BIT_OS]),
      .bg_en     (cfg0_r[BIT_BG]),
      .ofs_depth (avg_r[OFS_LSB +: 3]),
      .lin_avg   (avg_r[LIN_AVG_LSB +: 3]),
      .fg_complete (fg_complete),
      .halted    (halted),
      .bg_active (bg_act),
      .state     (eng_state)
   );

   assign cal_hold      = !run;
   assign divider_reset = !run;
   assign bg_cal_active = bg_act;
   assign fg_offset_active = (eng_state == ST_OS);
   assign bg_offset_active = bg_act && cfg0_r[BIT_BGOS];
   assign offset_averaging_depth    = avg_r[OFS_LSB +: 3];
   assign linearity_averaging_depth = avg_r[LIN_AVG_LSB +: 3];

   // Reserved idle-core code disables nothing
   always_comb begin
      core_disable = 3'h0;
      if (!cfg0_r[BIT_BG] && cfg2_r[1:0] != CORE_RSVD) begin
         core_disable[cfg2_r[1:0]] = 1'b1;
      end
   end

   a_div_follows_run: assert property (@(posedge mclk) disable iff (rst)
      divider_reset == !run_r[BIT_RUN]) else $error("divider reset wrong");
   a_bgos_gated: assert property (@(posedge mclk) disable iff (rst)
      bg_offset_active |-> cfg0_r[BIT_BG]) else $error("bg offset ungated");
   a_idle_core: assert property (@(posedge mclk) disable iff (rst)
      cfg0_r[BIT_BG] |-> core_disable == 3'h0) else $error("core off");
   a_wr_readback: assert property (@(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_AVG) |=> avg_r == $past(reg_wdata))
      else $error("avg not stored");
endmodule // cal_ctrl_regs
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top
   import cal_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic       mclk;
   logic       rst;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       cal_hold;
   logic       divider_reset;
   logic       fg_offset_active;
   logic       bg_offset_active;
   logic       bg_cal_active;
   logic [2:0] core_disable;
   logic [2:0] os_depth;
   logic [2:0] lin_depth;
   int         failures;
   int         comparisons;
   int         cycles;

   cal_ctrl_regs DUT (
      .mclk                      (mclk),
      .rst                       (rst),
      .reg_wr                    (reg_wr),
      .reg_rd                    (reg_rd),
      .reg_addr                  (reg_addr),
      .reg_wdata                 (reg_wdata),
      .reg_rdata                 (reg_rdata),
      .cal_hold                  (cal_hold),
      .divider_reset             (divider_reset),
      .fg_offset_active          (fg_offset_active),
      .bg_offset_active          (bg_offset_active),
      .bg_cal_active             (bg_cal_active),
      .core_disable              (core_disable),
      .offset_averaging_depth    (os_depth),
      .linearity_averaging_depth (lin_depth)
   );

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // ********************
   // Access tasks
   // ********************
   task automatic complete_run;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Whole run needs under one hundred fifty cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      #1;
      chk(n, e, reg_rdata);
   endtask

   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // Polls status, bounded, until the complete flag shows
   task automatic wait_done(input logic [7:0] e);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         reg_rd   <= 1'b1;
         reg_addr <= ADDR_STATE;
         @(posedge mclk);
         reg_rd   <= 1'b0;
         @(posedge mclk);
         #1;
         n++;
      end while (reg_rdata[0] !== 1'b1 && n < 200);
      chk("calibration_state", e, reg_rdata);
   endtask

   // ********************
   // Main sequence
   // ********************
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rdchk("calibration_state", 8'h6a, 8'h00);
      rdchk("calibration_run_enable", 8'h61, 8'h01);
      rdchk("calibration_config_zero", 8'h62, 8'h01);
      rdchk("calibration_config_two", 8'h64, 8'h02);
      rdchk("calibration_averaging", 8'h68, 8'h61);
      wait_done(8'h03);
      chk("cal_hold", 8'h00, cal_hold);
      wr(8'h61, 8'h00);
      settle();
      chk("cal_hold", 8'h01, cal_hold);
      chk("divider_reset", 8'h01, divider_reset);
      rdchk("calibration_state", 8'h6a, 8'h00);
      wr(8'h62, 8'hf0);
      rdchk("calibration_config_zero", 8'h62, 8'hf0);
      for (int i = 0; i < 4; i++) begin
         wr(8'h64, 8'(i));
         settle();
         chk("core_disable", (i == 3) ? 8'h00 : 8'(1 << i), core_disable);
      end
      wr(8'h64, 8'hfe);
      rdchk("calibration_config_two", 8'h64, 8'hfe);
      chk("core_disable", 8'h04, core_disable);
      wr(8'h68, 8'hff);
      rdchk("calibration_averaging", 8'h68, 8'hff);
      chk("offset_averaging_depth", 8'h07, os_depth);
      chk("linearity_averaging_depth", 8'h07, lin_depth);
      wr(8'h68, 8'h00);
      settle();
      chk("offset_averaging_depth", 8'h00, os_depth);
      chk("linearity_averaging_depth", 8'h00, lin_depth);
      wr(8'h62, 8'h05);
      wr(8'h61, 8'h01);
      for (int n = 0; n < 300 && fg_offset_active !== 1'b1; n++) settle();
      chk("fg_offset_active", 8'h01, fg_offset_active);
      wait_done(8'h03);
      wr(8'h61, 8'h00);
      wr(8'h62, 8'h0a);
      wr(8'h61, 8'h01);
      wait_done(8'h01);
      settle();
      chk("bg_cal_active", 8'h01, bg_cal_active);
      chk("bg_offset_active", 8'h01, bg_offset_active);
      chk("core_disable", 8'h00, core_disable);
      wr(8'h61, 8'h00);
      wr(8'h62, 8'h08);
      wr(8'h61, 8'h01);
      wait_done(8'h03);
      chk("bg_offset_active", 8'h00, bg_offset_active);
      chk("bg_cal_active", 8'h00, bg_cal_active);
      wr(8'h6a, 8'hff);
      rdchk("calibration_state", 8'h6a, 8'h03);
      rdchk("unmapped", 8'h70, 8'h00);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
